// >>> hw/flash_part_pkg.sv
// Constants, types and flash operation records for the partition sequencer
package flash_part_pkg;

  // Command codes
  localparam logic [7:0] CMD_FIRST = 8'h01;
  localparam logic [7:0] CMD_LAST = 8'h15;
  localparam logic [7:0] CMD_ERASE_VFY_ALL = 8'h01;
  localparam logic [7:0] CMD_ERASE_VFY_BLK = 8'h02;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
  localparam logic [7:0] CMD_UNSECURE = 8'h0b;
  localparam logic [7:0] CMD_BACKDOOR = 8'h0c;
  localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0e;
  localparam logic [7:0] CMD_FULL_PART = 8'h0f;
  localparam logic [7:0] CMD_EMUL_ENABLE = 8'h13;
  localparam logic [7:0] CMD_EMUL_DISABLE = 8'h14;
  localparam logic [7:0] CMD_EMUL_QUERY = 8'h15;
  localparam logic [7:0] CMD_PARTITION = 8'h20;

  // Partition limits, in 256-byte sectors, and the minimum ratio of emulation sectors to buffer sectors
  localparam int unsigned SECTOR_BYTES = 256;
  localparam int unsigned DF_SECTORS_MAX = 128;
  localparam int unsigned BUF_SECTORS_MAX = 16;
  localparam int unsigned EEE_SECTORS_MIN = 12;
  localparam int unsigned EEE_RATIO_MIN = 8;

  // Global addresses
  localparam logic [23:0] ADDR_DF_START = 24'h10_0000;
  localparam logic [23:0] ADDR_BUF_END = 24'h13_ffff;
  localparam logic [23:0] ADDR_DF_PART = 24'h12_0000;
  localparam logic [23:0] ADDR_DF_PART_DUP = 24'h12_0002;
  localparam logic [23:0] ADDR_BUF_PART = 24'h12_0004;
  localparam logic [23:0] ADDR_BUF_PART_DUP = 24'h12_0006;
  localparam logic [23:0] ADDR_SEC_BYTE = 24'h7f_ff0f;

  // Security
  localparam logic [7:0] SEC_REG_RESET = 8'hff;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;

  // Sequencer steps of the full-partition command
  localparam logic [2:0] STEP_ERASE_BLOCK = 3'h0;
  localparam logic [2:0] STEP_ERASE_INFO = 3'h1;
  localparam logic [2:0] STEP_PROG_DF = 3'h2;
  localparam logic [2:0] STEP_PROG_DF_DUP = 3'h3;
  localparam logic [2:0] STEP_PROG_BUF = 3'h4;
  localparam logic [2:0] STEP_LAST = 3'h5;

  typedef enum logic [1:0] {
    MODE_NORMAL_SINGLE_CHIP = 2'h0,
    MODE_NORMAL_EXPANDED = 2'h1,
    MODE_SPECIAL_SINGLE_CHIP = 2'h2,
    MODE_SPECIAL = 2'h3
  } chip_mode_e;

  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_ERASE_BLOCK = 2'h1,
    OP_ERASE_INFO = 2'h2,
    OP_PROGRAM = 2'h3
  } flash_op_e;

  typedef enum logic [4:0] {
    S_SECLD = 5'b00001,
    S_IDLE = 5'b00010,
    S_CHECK = 5'b00100,
    S_FLASH = 5'b01000,
    S_OTHER = 5'b10000
  } seq_state_e;

  typedef struct packed {
    flash_op_e op;
    logic [23:0] addr;
    logic [15:0] wdata;
  } flash_cmd_s;

  localparam flash_cmd_s FLASH_CMD_RESET = '{OP_READ, 24'h00_0000, 16'h0000};

endpackage : flash_part_pkg

// >>> hw/flash_partition_command_control.sv
// Flash command sequencer: full partition, mode checks, stop and security
`timescale 1ns/1ps

module flash_partition_command_control
  import flash_part_pkg::*;
#(
  parameter int unsigned DF_MAX = DF_SECTORS_MAX,
  parameter int unsigned BUF_MAX = BUF_SECTORS_MAX,
  parameter int unsigned EEE_MIN = EEE_SECTORS_MIN,
  parameter int unsigned RATIO_MIN = EEE_RATIO_MIN
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic launch_i,
  input wire logic [7:0] command_code_i,
  input wire logic [7:0] direct_sector_count_i,
  input wire logic [7:0] emul_buffer_sector_count_i,
  input wire logic complete_irq_enable_i,
  input wire chip_mode_e chip_mode_i,
  input wire logic stop_req_i,
  input wire logic emul_pending_i,
  input wire logic flash_done_i,
  input wire logic [7:0] flash_rdata_i,
  input wire logic other_done_i,
  output logic command_complete_flag_o,
  output logic access_error_o,
  output logic irq_o,
  output logic stop_ack_o,
  output logic flash_req_o,
  output flash_cmd_s flash_cmd_o,
  output logic other_req_o,
  output logic [7:0] security_config_reg_o,
  output logic secured_o
);

  localparam logic [8:0] DF_MAX_W = 9'(DF_MAX);
  localparam logic [8:0] BUF_MAX_W = 9'(BUF_MAX);
  localparam logic [8:0] EEE_MIN_W = 9'(EEE_MIN);
  localparam logic [12:0] RATIO_W = 13'(RATIO_MIN);

  seq_state_e st_ff;
  logic [2:0] step_ff;
  logic flash_req_ff;
  flash_cmd_s flash_cmd_ff;
  logic other_req_ff;
  logic command_complete_flag_ff;
  logic acc_err_ff;
  logic [7:0] sec_ff;
  logic [7:0] code_ff;
  logic [7:0] df_ff;
  logic [7:0] er_ff;
  logic launch_ok;
  logic cmd_ok;
  logic flash_ack;
  logic done_ev;
  logic reject_ev;
  logic secld_ev;
  logic [23:0] buf_start;

  // Floor division avoided: (a / er) >= 8 holds exactly when a >= 8 * er
  function automatic logic partition_ok(input logic [7:0] df,
                                        input logic [7:0] er);
    logic [8:0] room;
    room = DF_MAX_W - {1'b0, df};
    partition_ok = ({1'b0, df} <= DF_MAX_W)
      && ({1'b0, er} <= BUF_MAX_W)
      && ((er == 8'h00)
        || ((room >= EEE_MIN_W)
        && ({4'h0, room} >= RATIO_W * {5'h00, er})));
  endfunction : partition_ok

  function automatic logic cmd_allowed(input logic [7:0] code,
                                       input chip_mode_e mode,
                                       input logic sec);
    logic special;
    logic ns;
    special = (mode == MODE_SPECIAL_SINGLE_CHIP) || (mode == MODE_SPECIAL);
    ns = (mode == MODE_NORMAL_SINGLE_CHIP);
    if (!((code >= CMD_FIRST && code <= CMD_LAST)
        || code == CMD_PARTITION)) begin
      cmd_allowed = 1'b0;
    end else begin
      unique case (code)
        CMD_ERASE_ALL, CMD_UNSECURE: cmd_allowed = special;
        CMD_BACKDOOR: cmd_allowed = ns;
        CMD_FIELD_MARGIN, CMD_FULL_PART: cmd_allowed = special && !sec;
        CMD_ERASE_VFY_ALL, CMD_ERASE_VFY_BLK, CMD_EMUL_ENABLE,
        CMD_EMUL_DISABLE, CMD_EMUL_QUERY, CMD_PARTITION: begin
          cmd_allowed = 1'b1;
        end
        default: cmd_allowed = !sec || ns;
      endcase
    end
  endfunction : cmd_allowed

  // Step order puts both erases ahead of the four record writes
  function automatic flash_cmd_s step_cmd(input logic [2:0] step,
                                          input logic [7:0] df,
                                          input logic [7:0] er);
    unique case (step)
      STEP_ERASE_BLOCK: step_cmd = '{OP_ERASE_BLOCK, ADDR_DF_START, 16'h0000};
      STEP_ERASE_INFO: step_cmd = '{OP_ERASE_INFO, ADDR_DF_PART, 16'h0000};
      STEP_PROG_DF: step_cmd = '{OP_PROGRAM, ADDR_DF_PART, {8'h00, df}};
      STEP_PROG_DF_DUP: begin
        step_cmd = '{OP_PROGRAM, ADDR_DF_PART_DUP, {8'h00, df}};
      end
      STEP_PROG_BUF: step_cmd = '{OP_PROGRAM, ADDR_BUF_PART, {8'h00, er}};
      default: step_cmd = '{OP_PROGRAM, ADDR_BUF_PART_DUP, {8'h00, er}};
    endcase
  endfunction : step_cmd

  // Launch is the clear of a set complete flag while idle
  assign launch_ok = clk_en_i && launch_i && command_complete_flag_ff && st_ff == S_IDLE;
  assign cmd_ok = cmd_allowed(code_ff, chip_mode_i, secured_o)
    && (code_ff != CMD_FULL_PART || partition_ok(df_ff, er_ff));
  assign flash_ack = flash_req_ff && flash_done_i;
  assign buf_start = ADDR_BUF_END + 24'h00_0001 - {8'h00, er_ff, 8'h00};
  assign reject_ev = clk_en_i && st_ff == S_CHECK && !cmd_ok;
  assign secld_ev = clk_en_i && st_ff == S_SECLD && flash_ack;
  assign done_ev = reject_ev
    || (clk_en_i && st_ff == S_FLASH && flash_ack && step_ff == STEP_LAST)
    || (clk_en_i && st_ff == S_OTHER && other_done_i);

  // Parameters are latched at launch so later writes cannot skew a command
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      code_ff <= 8'h00;
      df_ff <= 8'h00;
      er_ff <= 8'h00;
    end else if (launch_ok) begin
      code_ff <= command_code_i;
      df_ff <= direct_sector_count_i;
      er_ff <= emul_buffer_sector_count_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= S_SECLD;
      step_ff <= STEP_ERASE_BLOCK;
      flash_req_ff <= 1'b0;
      flash_cmd_ff <= FLASH_CMD_RESET;
      other_req_ff <= 1'b0;
    end else if (clk_en_i) begin
      unique case (st_ff)
        S_SECLD: begin
          flash_cmd_ff <= '{OP_READ, ADDR_SEC_BYTE, 16'h0000};
          flash_req_ff <= !flash_ack;
          if (flash_ack) begin
            st_ff <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (launch_ok) begin
            st_ff <= S_CHECK;
          end
        end
        S_CHECK: begin
          if (!cmd_ok) begin
            st_ff <= S_IDLE;
          end else if (code_ff == CMD_FULL_PART) begin
            step_ff <= STEP_ERASE_BLOCK;
            st_ff <= S_FLASH;
          end else begin
            other_req_ff <= 1'b1;
            st_ff <= S_OTHER;
          end
        end
        S_FLASH: begin
          flash_cmd_ff <= step_cmd(step_ff, df_ff, er_ff);
          flash_req_ff <= !flash_ack;
          if (flash_ack) begin
            if (step_ff == STEP_LAST) begin
              st_ff <= S_IDLE;
            end else begin
              step_ff <= step_ff + 3'h1;
            end
          end
        end
        S_OTHER: begin
          if (other_done_i) begin
            other_req_ff <= 1'b0;
            st_ff <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Flag stays low until the security byte is in, so no launch races it
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      command_complete_flag_ff <= 1'b0;
    end else if (done_ev || secld_ev) begin
      command_complete_flag_ff <= 1'b1;
    end else if (launch_ok) begin
      command_complete_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_err_ff <= 1'b0;
    end else if (reject_ev) begin
      acc_err_ff <= 1'b1;
    end else if (launch_ok) begin
      acc_err_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sec_ff <= SEC_REG_RESET;
    end else if (secld_ev) begin
      sec_ff <= flash_rdata_i;
    end
  end

  assign command_complete_flag_o = command_complete_flag_ff;
  assign access_error_o = acc_err_ff;
  // Level request, raised while the complete flag and its enable are both set
  assign irq_o = command_complete_flag_ff && complete_irq_enable_i;
  assign stop_ack_o = stop_req_i && command_complete_flag_ff && !emul_pending_i;
  assign flash_req_o = flash_req_ff;
  assign flash_cmd_o = flash_cmd_ff;
  assign other_req_o = other_req_ff;
  assign security_config_reg_o = sec_ff;
  assign secured_o = sec_ff[1:0] != SEC_UNSECURED;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_df_limit;
    (st_ff == S_CHECK && clk_en_i && code_ff == CMD_FULL_PART
      && df_ff > 8'(DF_MAX)) |=> (st_ff == S_IDLE && acc_err_ff);
  endproperty
  a_df_limit: assert property (p_df_limit)
    else $error("direct count above limit not refused");

  property p_buf_limit;
    (st_ff == S_CHECK && clk_en_i && code_ff == CMD_FULL_PART
      && er_ff > 8'(BUF_MAX)) |=> acc_err_ff ##0 command_complete_flag_ff;
  endproperty
  a_buf_limit: assert property (p_buf_limit)
    else $error("buffer count above limit not refused");

  property p_ratio;
    (st_ff == S_CHECK && clk_en_i && code_ff == CMD_FULL_PART && cmd_ok)
      |-> (er_ff == 8'h00 || (9'(DF_MAX) - {1'b0, df_ff} >= 9'(EEE_MIN)
      && 13'(DF_MAX) - {5'h00, df_ff} >= 13'(RATIO_MIN) * {5'h00, er_ff}))
      && buf_start >= ADDR_BUF_END + 24'h00_0001 - 24'(BUF_MAX * SECTOR_BYTES);
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("partition accepted with too little emulation space");

  property p_no_work_on_reject;
    reject_ev |=> !flash_req_ff [*3];
  endproperty
  a_no_work_on_reject: assert property (p_no_work_on_reject)
    else $error("flash work started after refused command");

  property p_erase_first;
    (flash_req_ff && flash_cmd_ff.op == OP_PROGRAM)
      |-> step_ff >= STEP_PROG_DF;
  endproperty
  a_erase_first: assert property (p_erase_first)
    else $error("program issued before both erases");

  property p_records;
    (flash_req_ff && st_ff == S_FLASH && step_ff >= STEP_PROG_DF)
      |-> flash_cmd_ff.addr == ADDR_DF_PART + {21'h0, step_ff - 3'h2, 1'b0}
      && flash_cmd_ff.wdata[7:0] == (step_ff < STEP_PROG_BUF ? df_ff : er_ff);
  endproperty
  a_records: assert property (p_records)
    else $error("partition record at wrong address or value");

  property p_complete;
    (st_ff == S_FLASH && clk_en_i && flash_ack && step_ff == STEP_LAST)
      |=> command_complete_flag_ff && st_ff == S_IDLE && !acc_err_ff;
  endproperty
  a_complete: assert property (p_complete)
    else $error("complete flag not set after partition");

  property p_unsupported;
    (st_ff == S_CHECK && clk_en_i && code_ff > CMD_LAST
      && code_ff != CMD_PARTITION) |=> acc_err_ff && !other_req_ff;
  endproperty
  a_unsupported: assert property (p_unsupported)
    else $error("unsupported code was run");

  property p_mode_limits;
    (st_ff == S_CHECK && clk_en_i && cmd_ok) |->
      !((code_ff == CMD_ERASE_ALL || code_ff == CMD_UNSECURE)
        && chip_mode_i < MODE_SPECIAL_SINGLE_CHIP)
      && !(code_ff == CMD_BACKDOOR && chip_mode_i != MODE_NORMAL_SINGLE_CHIP)
      && !(code_ff == CMD_FULL_PART
        && (secured_o || chip_mode_i < MODE_SPECIAL_SINGLE_CHIP))
      && !(secured_o && chip_mode_i != MODE_NORMAL_SINGLE_CHIP
        && code_ff == 8'h03);
  endproperty
  a_mode_limits: assert property (p_mode_limits)
    else $error("command ran in a forbidden mode");

  property p_stop;
    stop_ack_o |-> command_complete_flag_ff && !emul_pending_i && st_ff == S_IDLE;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop granted during flash activity");

  property p_sec_load;
    secld_ev |=> sec_ff == $past(flash_rdata_i) && command_complete_flag_ff;
  endproperty
  a_sec_load: assert property (p_sec_load)
    else $error("security register not loaded from flash byte");

  property p_irq;
    $rose(command_complete_flag_ff) && complete_irq_enable_i |-> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("complete interrupt missing");

endmodule : flash_partition_command_control

// >>> testbench/flash_partition_command_control_tb_top.sv
// Self-checking bench for the flash partition command sequencer
`timescale 1ns/1ps

module flash_partition_command_control_tb_top
  import flash_part_pkg::*;
;
  logic ref_clk_i;
  logic rst_i;
  logic clk_en_i;
  logic launch_i;
  logic [7:0] command_code_i;
  logic [7:0] direct_sector_count_i;
  logic [7:0] emul_buffer_sector_count_i;
  logic complete_irq_enable_i;
  chip_mode_e chip_mode_i;
  logic stop_req_i;
  logic emul_pending_i;
  logic flash_done_i;
  logic [7:0] sec_byte;
  logic other_done_i;
  logic command_complete_flag_o;
  logic access_error_o;
  logic irq_o;
  logic stop_ack_o;
  logic flash_req_o;
  flash_cmd_s flash_cmd_o;
  logic other_req_o;
  logic [7:0] security_config_reg_o;
  logic secured_o;
  int errors;
  int n_checks;
  logic sec_now;
  logic prev_flag;
  logic prev_req;
  logic other_seen;
  logic stop_exp;
  logic [1:0] note;
  flash_cmd_s want;
  flash_cmd_s exp_cmd[$];
  logic [1:0] exp_note[$];

  flash_partition_command_control DUT (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clk_en_i(clk_en_i),
    .launch_i(launch_i),
    .command_code_i(command_code_i),
    .direct_sector_count_i(direct_sector_count_i),
    .emul_buffer_sector_count_i(emul_buffer_sector_count_i),
    .complete_irq_enable_i(complete_irq_enable_i),
    .chip_mode_i(chip_mode_i),
    .stop_req_i(stop_req_i),
    .emul_pending_i(emul_pending_i),
    .flash_done_i(flash_done_i),
    .flash_rdata_i(sec_byte),
    .other_done_i(other_done_i),
    .command_complete_flag_o(command_complete_flag_o),
    .access_error_o(access_error_o),
    .irq_o(irq_o),
    .stop_ack_o(stop_ack_o),
    .flash_req_o(flash_req_o),
    .flash_cmd_o(flash_cmd_o),
    .other_req_o(other_req_o),
    .security_config_reg_o(security_config_reg_o),
    .secured_o(secured_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic test_done();
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Independent permission table per code, mode and security state
  function automatic logic allowed(input logic [7:0] c, input chip_mode_e m,
                                   input logic sec);
    logic sp;
    sp = (m == MODE_SPECIAL_SINGLE_CHIP) || (m == MODE_SPECIAL);
    if (!((c >= 8'h01 && c <= 8'h15) || c == 8'h20)) return 1'b0;
    if (c == 8'h08 || c == 8'h0b) return sp;
    if (c == 8'h0c) return m == MODE_NORMAL_SINGLE_CHIP;
    if (c == 8'h0e || c == 8'h0f) return sp && !sec;
    if (sec && m != MODE_NORMAL_SINGLE_CHIP) begin
      return c inside {8'h01, 8'h02, 8'h13, 8'h14, 8'h15, 8'h20};
    end
    return 1'b1;
  endfunction : allowed

  function automatic logic counts_ok(input logic [7:0] df,
                                     input logic [7:0] er);
    int d;
    int e;
    d = df;
    e = er;
    if (d > 128 || e > 16) return 1'b0;
    if (e == 0) return 1'b1;
    return (128 - d) >= 12 && ((128 - d) / e) >= 8;
  endfunction : counts_ok

  task automatic wait_flag(input logic v);
    int i;
    for (i = 0; i < 300 && command_complete_flag_o !== v; i++) begin
      @(negedge ref_clk_i);
    end
    if (i == 300) check(command_complete_flag_o, v);
  endtask : wait_flag

  task automatic do_reset(input logic [7:0] sb);
    @(negedge ref_clk_i);
    rst_i <= 1'b1;
    sec_byte <= sb;
    launch_i <= 1'b0;
    repeat (5) @(negedge ref_clk_i);
    exp_cmd.delete();
    exp_note.delete();
    exp_cmd.push_back('{OP_READ, ADDR_SEC_BYTE, 16'h0000});
    exp_note.push_back(2'b00);
    sec_now = (sb[1:0] != 2'b10);
    rst_i <= 1'b0;
    wait_flag(1'b1);
    check(security_config_reg_o, sb);
    check(secured_o, sec_now);
  endtask : do_reset

  task automatic run_cmd(input logic [7:0] c, input logic [7:0] df,
                         input logic [7:0] er, input chip_mode_e m);
    @(negedge ref_clk_i);
    command_code_i <= c;
    direct_sector_count_i <= df;
    emul_buffer_sector_count_i <= er;
    chip_mode_i <= m;
    launch_i <= 1'b1;
    if (!allowed(c, m, sec_now)) begin
      exp_note.push_back(2'b10);
    end else if (c == CMD_FULL_PART && !counts_ok(df, er)) begin
      exp_note.push_back(2'b10);
    end else if (c == CMD_FULL_PART) begin
      exp_cmd.push_back('{OP_ERASE_BLOCK, ADDR_DF_START, 16'h0000});
      exp_cmd.push_back('{OP_ERASE_INFO, ADDR_DF_PART, 16'h0000});
      exp_cmd.push_back('{OP_PROGRAM, ADDR_DF_PART, {8'h00, df}});
      exp_cmd.push_back('{OP_PROGRAM, ADDR_DF_PART_DUP, {8'h00, df}});
      exp_cmd.push_back('{OP_PROGRAM, ADDR_BUF_PART, {8'h00, er}});
      exp_cmd.push_back('{OP_PROGRAM, ADDR_BUF_PART_DUP, {8'h00, er}});
      exp_note.push_back(2'b00);
    end else begin
      exp_note.push_back(2'b01);
    end
    // Launch is held until taken, since a frozen clock may skip an edge
    wait_flag(1'b0);
    launch_i <= 1'b0;
    wait_flag(1'b1);
  endtask : run_cmd

  // Far-side answers come after a random delay so slow and fast paths run
  always @(negedge ref_clk_i) begin
    flash_done_i <= flash_req_o && !flash_done_i && ($urandom_range(0, 2) == 0);
    other_done_i <= other_req_o && !other_done_i && ($urandom_range(0, 1) == 0);
    complete_irq_enable_i <= 1'($urandom_range(0, 1));
    stop_req_i <= 1'($urandom_range(0, 1));
    clk_en_i <= ($urandom_range(0, 3) != 0);
    emul_pending_i <= ($urandom_range(0, 3) == 0);
  end

  always @(negedge ref_clk_i) begin
    if (rst_i) begin
      prev_flag = 1'b0;
      prev_req = 1'b0;
      other_seen = 1'b0;
    end else begin
      if (flash_req_o && !prev_req) begin
        check(exp_cmd.size() != 0, 1'b1);
        if (exp_cmd.size() != 0) begin
          want = exp_cmd.pop_front();
          check(flash_cmd_o, want);
        end
      end
      if (other_req_o) other_seen = 1'b1;
      if (command_complete_flag_o && !prev_flag) begin
        check(exp_note.size() != 0, 1'b1);
        if (exp_note.size() != 0) begin
          note = exp_note.pop_front();
          check(access_error_o, note[1]);
          check(other_seen, note[0]);
        end
        other_seen = 1'b0;
      end
      check(irq_o, command_complete_flag_o & complete_irq_enable_i);
      stop_exp = stop_req_i & command_complete_flag_o & !emul_pending_i;
      check(stop_ack_o, stop_exp);
      prev_flag = command_complete_flag_o;
      prev_req = flash_req_o;
    end
  end

  // Boundary counts: each pass and each fail edge of the four checks
  logic [7:0] df_tab[10] = '{8'd128, 8'd129, 8'd116, 8'd117, 8'd0,
                             8'd0, 8'd64, 8'd65, 8'd112, 8'd113};
  logic [7:0] er_tab[10] = '{8'd0, 8'd0, 8'd1, 8'd1, 8'd16,
                             8'd17, 8'd8, 8'd8, 8'd2, 8'd2};

  initial begin
    rst_i = 1'b1;
    clk_en_i = 1'b1;
    launch_i = 1'b0;
    command_code_i = 8'h00;
    direct_sector_count_i = 8'h00;
    emul_buffer_sector_count_i = 8'h00;
    complete_irq_enable_i = 1'b0;
    chip_mode_i = MODE_NORMAL_SINGLE_CHIP;
    stop_req_i = 1'b0;
    emul_pending_i = 1'b0;
    flash_done_i = 1'b0;
    other_done_i = 1'b0;
    sec_byte = 8'hff;
    errors = 0;
    n_checks = 0;
    void'($urandom(32'hb841a824));
    do_reset(8'hff);
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 8'h23; c++) begin
        run_cmd(c[7:0], 8'h00, 8'h00, chip_mode_e'(m[1:0]));
      end
    end
    // Second reset mid-run brings the part up unsecured
    do_reset(8'hfe);
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 8'h23; c++) begin
        run_cmd(c[7:0], 8'($urandom_range(0, 140)), 8'($urandom_range(0, 18)),
                chip_mode_e'(m[1:0]));
      end
    end
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 10; i++) begin
        run_cmd(CMD_FULL_PART, df_tab[i], er_tab[i],
                k ? MODE_SPECIAL : MODE_SPECIAL_SINGLE_CHIP);
      end
    end
    repeat (10) @(negedge ref_clk_i);
    check(exp_cmd.size(), 0);
    check(exp_note.size(), 0);
    test_done();
  end

  // About 300 commands of a few dozen cycles each fit well inside this span
  initial begin
    #400000;
    errors++;
    test_done();
  end

endmodule : flash_partition_command_control_tb_top
